/* File: src/refsw_pkg.sv */
// Constants for reference switchover and loop divider control
package refsw_pkg;
  // Reference input dividers, first loop
  localparam int unsigned REF_DIV_W       = 10;
  localparam logic [9:0]  REF_DIV_MIN     = 10'h001;
  localparam logic [9:0]  REF_DIV_MAX     = 10'h3FF;
  // Second loop reference divider
  localparam int unsigned L2_DIV_W        = 5;
  localparam logic [4:0]  L2_DIV_MAX      = 5'h1F;
  // Normal feedback path
  localparam int unsigned FB_CNT_W        = 8;
  localparam int unsigned FB_RATIO_W      = 11;
  localparam logic [1:0]  RF_DIV_CODE_3   = 2'h0;
  localparam logic [1:0]  RF_DIV_CODE_4   = 2'h1;
  localparam logic [1:0]  RF_DIV_CODE_5   = 2'h2;
  localparam logic [2:0]  RF_DIV_3        = 3'h3;
  localparam logic [2:0]  RF_DIV_4        = 3'h4;
  localparam logic [2:0]  RF_DIV_5        = 3'h5;
  // Calibration feedback divider
  localparam int unsigned CAL_B_W         = 6;
  localparam int unsigned CAL_A_W         = 2;
  localparam logic [2:0]  CAL_PRESCALE    = 3'h4;
  localparam logic [5:0]  CAL_B_MIN       = 6'h03;
  localparam logic [5:0]  CAL_B_MAX       = 6'h3F;
  localparam logic [1:0]  CAL_A_MAX       = 2'h3;
  localparam logic [10:0] CAL_RATIO_MIN   = 11'h010;
  // Reset values of control state
  localparam logic        RST_ACTIVE_SEC  = 1'b0;
  localparam logic        RST_STICKY      = 1'b0;
  localparam logic        RST_HOLDOVER    = 1'b0;
  localparam logic        RST_CAL_BUSY    = 1'b0;
endpackage

/* File: src/reference_switchover_divider_ctrl.sv */
// Reference selection, holdover and loop divider control
`timescale 1ns/100ps

// What this block does
// - Each reference has its own divider, ratio 1 through 1023.
// - Manual selection comes from a config bit or the select pin.
// - Auto mode moves to secondary when primary lost and secondary present.
// - Nonrevertive: stay on secondary; return only when secondary vanishes.
// - Revertive: go to secondary on loss, return when primary reappears.
// - Primary return or mode toggling does not clear nonrevertive state.
// - Only device reset clears the switchover state.
// - No reference present: holdover, charge pump tristated.
// - Option drives tune node to mid-supply in holdover instead.
// - Leave holdover when a reference returns, resync first loop.
// - A config bit disables automatic holdover entry.
// - Second loop stays on the oscillator during holdover.
// - Differential receiver off unless selected and first loop powered.
// - Single-ended buffers off on loop off, own setting, or diff selected.
// - Optional bypassable doubler on the second loop reference path.
// - Second loop reference divider ratio 1 through 31.
// - Normal feedback ratio is feedback counter times RF divider.
// - RF output divider ratios three, four or five.
// - Calibration ratio is four times counter B plus counter A.
// - B from 3 to 63, A from 0 to 3, total at least 16.
// - Calibration path only during calibration, then normal path.
// - Calibrate bit rising starts calibration; busy flag clears at end.
module reference_switchover_divider_ctrl #(
  parameter int unsigned REF_W = refsw_pkg::REF_DIV_W
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              primary_present,
  input  wire logic              secondary_present,
  input  wire logic              primary_reference_tick,
  input  wire logic              secondary_reference_tick,
  input  wire logic              oscillator_input_tick,
  input  wire logic              vco_tick,
  input  wire logic              auto_mode,
  input  wire logic              revertive,
  input  wire logic              manual_sel_secondary,
  input  wire logic              use_select_pin,
  input  wire logic              ref_select_pin,
  input  wire logic              holdover_disable,
  input  wire logic              holdover_mid_supply,
  input  wire logic              first_loop_pd,
  input  wire logic              diff_input_sel,
  input  wire logic              se_primary_pd_cfg,
  input  wire logic              se_secondary_pd_cfg,
  input  wire logic [REF_W-1:0]  primary_div_ratio,
  input  wire logic [REF_W-1:0]  secondary_div_ratio,
  input  wire logic              doubler_en,
  input  wire logic [4:0]        loop2_reference_divider,
  input  wire logic [7:0]        feedback_counter,
  input  wire logic [1:0]        rf_output_divider,
  input  wire logic [5:0]        cal_counter_b,
  input  wire logic [1:0]        cal_counter_a,
  input  wire logic              calibrate,
  input  wire logic              cal_finished,
  output logic                   pfd_reference_pulse,
  output logic                   loop2_ref_pulse,
  output logic                   feedback_pulse,
  output logic [10:0]            feedback_ratio,
  output logic                   cal_path_active,
  output logic                   cal_in_progress,
  output logic                   cal_cfg_error,
  output logic                   cal_ratio_mismatch,
  output logic                   cp_tristate,
  output logic                   cp_force_mid,
  output logic                   loop1_resync,
  output logic                   diff_rx_pd,
  output logic                   se_primary_pd,
  output logic                   se_secondary_pd,
  output logic                   active_is_secondary,
  output logic                   primary_present_stat,
  output logic                   secondary_present_stat,
  output logic                   holdover_active
);

  // Refuse widths the divider range cannot hold
  if (REF_W < 10 || REF_W > 16) begin : g_bad_width
    $error("REF_W must be between 10 and 16");
  end

  // Selection and holdover state
  logic active_sec_q, active_sec_d;
  logic sticky_q, sticky_d;
  logic holdover_q, holdover_d;
  logic resync_q;
  logic prim_stat_q, sec_stat_q;

  // Selection decode
  wire  manual_sec = use_select_pin ? ref_select_pin
                                    : manual_sel_secondary;
  wire  none_present = !primary_present && !secondary_present;
  wire  enter_hold = none_present && !holdover_disable;
  wire  leave_hold = holdover_q && !none_present;
  wire  go_sec = !active_sec_q && !primary_present
                 && secondary_present;
  wire  back_lost = active_sec_q && !secondary_present
                    && primary_present;
  wire  back_revert = active_sec_q && revertive && !sticky_q
                      && primary_present;

  // Next active reference; primary is the reset choice
  always_comb begin
    active_sec_d = active_sec_q;
    sticky_d     = sticky_q;
    if (!auto_mode) begin
      // Secondary assumed already present when picked by hand
      active_sec_d = manual_sec;
    end else if (holdover_q && leave_hold) begin
      // Sticky secondary that came back keeps the selection
      active_sec_d = !primary_present
                     || (active_sec_q && sticky_q
                         && secondary_present);
    end else if (!holdover_q) begin
      if (go_sec) begin
        active_sec_d = 1'b1;
        if (!revertive) begin
          sticky_d = 1'b1;
        end
      end else if (back_lost || back_revert) begin
        active_sec_d = 1'b0;
      end
    end
  end

  // Holdover next state
  always_comb begin
    holdover_d = holdover_q;
    if (!holdover_q && enter_hold) begin
      holdover_d = 1'b1;
    end else if (leave_hold) begin
      holdover_d = 1'b0;
    end
  end

  // Switchover state; sticky bit cleared by reset only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active_sec_q <= refsw_pkg::RST_ACTIVE_SEC;
      sticky_q     <= refsw_pkg::RST_STICKY;
      holdover_q   <= refsw_pkg::RST_HOLDOVER;
      resync_q     <= 1'b0;
    end else begin
      active_sec_q <= active_sec_d;
      sticky_q     <= sticky_d;
      holdover_q   <= holdover_d;
      resync_q     <= leave_hold;
    end
  end

  // Presence status flags
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prim_stat_q <= 1'b0;
      sec_stat_q  <= 1'b0;
    end else begin
      prim_stat_q <= primary_present;
      sec_stat_q  <= secondary_present;
    end
  end

  assign active_is_secondary    = active_sec_q;
  assign holdover_active        = holdover_q;
  assign primary_present_stat   = prim_stat_q;
  assign secondary_present_stat = sec_stat_q;
  assign loop1_resync           = resync_q;

  // Charge pump behaviour in holdover
  assign cp_tristate  = holdover_q && !holdover_mid_supply;
  assign cp_force_mid = holdover_q && holdover_mid_supply;

  // Receiver power-down
  assign diff_rx_pd      = !diff_input_sel || first_loop_pd;
  assign se_primary_pd   = first_loop_pd || se_primary_pd_cfg
                           || diff_input_sel;
  assign se_secondary_pd = first_loop_pd || se_secondary_pd_cfg
                           || diff_input_sel;

  // Per-reference input dividers, zero treated as one
  logic [REF_W-1:0] rdiv_cnt_q [2];
  logic [1:0]       rdiv_pulse_q;
  wire  [1:0]       rdiv_tick = {secondary_reference_tick,
                                 primary_reference_tick};
  wire  [REF_W-1:0] rdiv_ratio [2];
  assign rdiv_ratio[0] = primary_div_ratio;
  assign rdiv_ratio[1] = secondary_div_ratio;

  for (genvar i = 0; i < 2; i++) begin : g_ref_div
    wire [REF_W-1:0] last = (rdiv_ratio[i] == '0) ? '0
                            : REF_W'(rdiv_ratio[i] - 1'b1);
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        rdiv_cnt_q[i]   <= '0;
        rdiv_pulse_q[i] <= 1'b0;
      end else if (rdiv_tick[i]) begin
        rdiv_cnt_q[i]   <= (rdiv_cnt_q[i] >= last) ? '0
                           : REF_W'(rdiv_cnt_q[i] + 1'b1);
        rdiv_pulse_q[i] <= (rdiv_cnt_q[i] >= last);
      end else begin
        rdiv_pulse_q[i] <= 1'b0;
      end
    end
  end

  // Divided active reference to the phase detector, muted in holdover
  assign pfd_reference_pulse = rdiv_pulse_q[active_sec_q] && !holdover_q;

  // Second loop reference path; runs off oscillator regardless of holdover
  logic [5:0] l2_acc_q;
  logic       l2_pulse_q;
  wire  [5:0] l2_ratio = (loop2_reference_divider == 5'h00) ? 6'h01
                         : {1'b0, loop2_reference_divider};
  wire  [5:0] l2_step  = doubler_en ? 6'h02 : 6'h01;
  wire  [6:0] l2_sum   = {1'b0, l2_acc_q} + {1'b0, l2_step};
  wire        l2_wrap  = l2_sum >= {1'b0, l2_ratio};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      l2_acc_q   <= '0;
      l2_pulse_q <= 1'b0;
    end else if (oscillator_input_tick) begin
      l2_acc_q   <= l2_wrap ? 6'(l2_sum - {1'b0, l2_ratio})
                            : l2_sum[5:0];
      l2_pulse_q <= l2_wrap;
    end else begin
      l2_pulse_q <= 1'b0;
    end
  end
  assign loop2_ref_pulse = l2_pulse_q;

  // Feedback ratios
  wire  [2:0]  m1_val = (rf_output_divider == refsw_pkg::RF_DIV_CODE_4)
                        ? refsw_pkg::RF_DIV_4
                        : (rf_output_divider == refsw_pkg::RF_DIV_CODE_5)
                        ? refsw_pkg::RF_DIV_5
                        : refsw_pkg::RF_DIV_3;
  wire  [10:0] norm_ratio = 11'({3'h0, feedback_counter}
                                * {8'h00, m1_val});
  wire  [10:0] cal_ratio  = 11'({3'h0, cal_counter_b}
                                * refsw_pkg::CAL_PRESCALE)
                            + {9'h000, cal_counter_a};
  assign cal_cfg_error = (cal_counter_b < refsw_pkg::CAL_B_MIN)
                         || (cal_ratio < refsw_pkg::CAL_RATIO_MIN);
  assign cal_ratio_mismatch = cal_ratio != norm_ratio;

  // Calibration sequencing; a new start beats a finish in the same cycle
  logic cal_q, cal_busy_q;
  wire  cal_start = calibrate && !cal_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cal_q      <= 1'b0;
      cal_busy_q <= refsw_pkg::RST_CAL_BUSY;
    end else begin
      cal_q      <= calibrate;
      cal_busy_q <= cal_start ? 1'b1
                    : cal_finished ? 1'b0 : cal_busy_q;
    end
  end
  assign cal_in_progress = cal_busy_q;
  assign cal_path_active = cal_busy_q;

  // Feedback divider on the selected path
  logic [10:0] fb_cnt_q;
  logic        fb_pulse_q;
  assign feedback_ratio = cal_busy_q ? cal_ratio : norm_ratio;
  wire  [10:0] fb_last = (feedback_ratio == 11'h000) ? 11'h000
                         : 11'(feedback_ratio - 1'b1);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fb_cnt_q   <= '0;
      fb_pulse_q <= 1'b0;
    end else if (vco_tick) begin
      fb_cnt_q   <= (fb_cnt_q >= fb_last) ? 11'h000
                    : 11'(fb_cnt_q + 1'b1);
      fb_pulse_q <= fb_cnt_q >= fb_last;
    end else begin
      fb_pulse_q <= 1'b0;
    end
  end
  assign feedback_pulse = fb_pulse_q;

  // Checks on the selection, holdover and calibration behaviour
  a_auto_switch: assert property (
    @(posedge ref_clk) disable iff (rst)
    auto_mode && !holdover_q && !active_sec_q && !primary_present
    && secondary_present |=> active_sec_q)
    else $error("no move to secondary on primary loss");

  a_revert_back: assert property (
    @(posedge ref_clk) disable iff (rst)
    auto_mode && revertive && !sticky_q && !holdover_q && active_sec_q
    && primary_present |=> !active_sec_q)
    else $error("revertive mode did not return to primary");

  a_nonrev_stay: assert property (
    @(posedge ref_clk) disable iff (rst)
    auto_mode && sticky_q && active_sec_q && secondary_present
    |=> active_sec_q)
    else $error("nonrevertive mode left a present secondary");

  a_sticky_kept: assert property (
    @(posedge ref_clk) disable iff (rst)
    sticky_q |=> sticky_q [*3])
    else $error("switchover state cleared without reset");

  a_hold_entry: assert property (
    @(posedge ref_clk) disable iff (rst)
    !primary_present && !secondary_present && !holdover_disable
    |=> holdover_q && (cp_tristate != holdover_mid_supply))
    else $error("holdover not entered with both references gone");

  a_hold_blocked: assert property (
    @(posedge ref_clk) disable iff (rst)
    !holdover_q && holdover_disable |=> !holdover_q)
    else $error("holdover entered while disabled");

  a_hold_exit: assert property (
    @(posedge ref_clk) disable iff (rst)
    holdover_q && (primary_present || secondary_present)
    |=> !holdover_q && loop1_resync ##1 !loop1_resync)
    else $error("holdover exit or resync pulse wrong");

  a_cal_start: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(calibrate) && !cal_in_progress
    |=> cal_in_progress && feedback_ratio == cal_ratio)
    else $error("calibration did not start on rising calibrate");

  a_cal_return: assert property (
    @(posedge ref_clk) disable iff (rst)
    cal_in_progress && cal_finished && !cal_start
    |=> !cal_path_active && feedback_ratio == norm_ratio)
    else $error("feedback path did not revert after calibration");

endmodule

/* File: tb/ref_source_model.sv */
// Reference sources and oscillator feeding the switchover block
`timescale 1ns/100ps
module ref_source_model (
  input  wire logic ref_clk,
  input  wire logic prim_on,
  input  wire logic sec_on,
  input  wire logic slow,
  output logic      primary_present,
  output logic      secondary_present,
  output logic      primary_reference_tick,
  output logic      secondary_reference_tick,
  output logic      oscillator_input_tick,
  output logic      vco_tick
);
  logic phase_q;
  // Monitor sees each source as soon as it runs
  assign primary_present   = prim_on;
  assign secondary_present = sec_on;
  initial begin
    phase_q = 1'b0;
    {primary_reference_tick, secondary_reference_tick} = 2'h0;
    {oscillator_input_tick, vco_tick} = 2'h0;
  end
  // Reference edges every cycle, or every other cycle when slow, none when absent; oscillator and VCO edges every cycle
  always @(posedge ref_clk) begin
    phase_q <= #1 ~phase_q;
    primary_reference_tick <= #1 prim_on & (~slow | phase_q);
    secondary_reference_tick <= #1 sec_on & (~slow | phase_q);
    oscillator_input_tick <= #1 1'b1;
    vco_tick <= #1 1'b1;
  end
endmodule

/* File: tb/reference_switchover_divider_ctrl_bench.sv */
// Self-checking bench for reference switchover and divider control
`timescale 1ns/100ps
module reference_switchover_divider_ctrl_bench;
  typedef struct packed {
    logic [3:0]  pd;
    logic [7:0]  n;
    logic [1:0]  m;
    logic [5:0]  b;
    logic [1:0]  a;
    logic [10:0] ratio;
  } row_s;
  logic ref_clk, rst, prim_on, sec_on, slow;
  logic primary_present, secondary_present, primary_reference_tick;
  logic secondary_reference_tick, oscillator_input_tick, vco_tick;
  logic auto_mode, revertive, manual_sel_secondary, use_select_pin;
  logic ref_select_pin, holdover_disable, holdover_mid_supply;
  logic first_loop_pd, diff_input_sel, se_primary_pd_cfg;
  logic se_secondary_pd_cfg, doubler_en, calibrate, cal_finished;
  logic [9:0] primary_div_ratio, secondary_div_ratio;
  logic [4:0] loop2_reference_divider;
  logic [7:0] feedback_counter;
  logic [1:0] rf_output_divider, cal_counter_a;
  logic [5:0] cal_counter_b;
  logic [10:0] feedback_ratio;
  logic pfd_reference_pulse, loop2_ref_pulse, feedback_pulse;
  logic cal_path_active, cal_in_progress, cal_cfg_error;
  logic cal_ratio_mismatch, cp_tristate, cp_force_mid, loop1_resync;
  logic diff_rx_pd, se_primary_pd, se_secondary_pd, active_is_secondary;
  logic primary_present_stat, secondary_present_stat, holdover_active;
  int fails, checks_done, cycles, g, cb;
  row_s rows [5] = '{'{4'h0, 8'h0A, 2'h0, 6'h07, 2'h2, 11'h01E},
                     '{4'h4, 8'h08, 2'h1, 6'h03, 2'h3, 11'h020},
                     '{4'h8, 8'hFF, 2'h2, 6'h3F, 2'h3, 11'h4FB},
                     '{4'h3, 8'h05, 2'h3, 6'h02, 2'h0, 11'h00F},
                     '{4'h5, 8'h04, 2'h1, 6'h04, 2'h0, 11'h010}};
  ref_source_model src (.ref_clk, .prim_on, .sec_on, .slow,
    .primary_present, .secondary_present, .primary_reference_tick,
    .secondary_reference_tick, .oscillator_input_tick, .vco_tick);
  reference_switchover_divider_ctrl uut (.ref_clk, .rst, .primary_present,
    .secondary_present, .primary_reference_tick, .secondary_reference_tick,
    .oscillator_input_tick, .vco_tick, .auto_mode, .revertive,
    .manual_sel_secondary, .use_select_pin, .ref_select_pin,
    .holdover_disable, .holdover_mid_supply, .first_loop_pd,
    .diff_input_sel, .se_primary_pd_cfg, .se_secondary_pd_cfg,
    .primary_div_ratio, .secondary_div_ratio, .doubler_en,
    .loop2_reference_divider, .feedback_counter, .rf_output_divider,
    .cal_counter_b, .cal_counter_a, .calibrate, .cal_finished,
    .pfd_reference_pulse, .loop2_ref_pulse, .feedback_pulse,
    .feedback_ratio, .cal_path_active, .cal_in_progress, .cal_cfg_error,
    .cal_ratio_mismatch, .cp_tristate, .cp_force_mid, .loop1_resync,
    .diff_rx_pd, .se_primary_pd, .se_secondary_pd, .active_is_secondary,
    .primary_present_stat, .secondary_present_stat, .holdover_active);
  // Clock source, 10 ns period
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Comparison with count of misses
  task check(input logic [31:0] seen, input logic [31:0] exp, string what);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  // Waits edges, then lands just after the last one
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return pfd_reference_pulse;
      1: return loop2_ref_pulse;
      default: return feedback_pulse;
    endcase
  endfunction
  // Cycles between divider pulses, after two to settle
  task gap(input int w, output int n);
    int k;
    for (k = 0; k < 2; k++) begin
      n = 0;
      while (pick(w) !== 1'b1 && n < 5000) begin
        cyc(1);
        n++;
      end
      cyc(1);
    end
    n = 1;
    while (pick(w) !== 1'b1 && n < 5000) begin
      cyc(1);
      n++;
    end
  endtask
  task report_and_stop;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    {rst, prim_on, sec_on, slow, auto_mode} = 5'h1F;
    slow = 1'b0;
    {revertive, manual_sel_secondary, use_select_pin} = 3'h0;
    {ref_select_pin, holdover_disable, holdover_mid_supply} = 3'h0;
    {first_loop_pd, diff_input_sel, se_primary_pd_cfg} = 3'h0;
    {se_secondary_pd_cfg, doubler_en, calibrate, cal_finished} = 4'h0;
    primary_div_ratio = 10'h3FF;
    secondary_div_ratio = 10'h007;
    loop2_reference_divider = 5'h1F;
    {feedback_counter, rf_output_divider} = {8'h0A, 2'h0};
    {cal_counter_b, cal_counter_a} = {6'h07, 2'h2};
    {fails, checks_done, cycles} = 0;
    cyc(12);
    rst = 1'b0;
    cyc(1);
    check(active_is_secondary, 0, "reset sel");
    check(holdover_active, 0, "reset hold");
    check(cal_in_progress, 0, "reset cal");
    $display("reset test done");
    // Table of divider settings and power-down combinations
    foreach (rows[i]) begin
      {first_loop_pd, diff_input_sel, se_primary_pd_cfg,
       se_secondary_pd_cfg} = rows[i].pd;
      {feedback_counter, rf_output_divider} = {rows[i].n, rows[i].m};
      {cal_counter_b, cal_counter_a} = {rows[i].b, rows[i].a};
      cb = 4 * rows[i].b + rows[i].a;
      cyc(1);
      check(feedback_ratio, rows[i].ratio, "ratio");
      check(diff_rx_pd, first_loop_pd | !diff_input_sel, "dpd");
      check(se_primary_pd, first_loop_pd | se_primary_pd_cfg |
            diff_input_sel, "sepd a");
      check(se_secondary_pd, first_loop_pd | se_secondary_pd_cfg |
            diff_input_sel, "sepd b");
      check(cal_cfg_error, rows[i].b < 3 || cb < 16, "cfg");
      check(cal_ratio_mismatch, cb != rows[i].ratio, "mis");
    end
    {first_loop_pd, diff_input_sel, se_primary_pd_cfg} = 3'h0;
    se_secondary_pd_cfg = 1'b0;
    {feedback_counter, rf_output_divider} = {8'h0A, 2'h0};
    {cal_counter_b, cal_counter_a} = {6'h07, 2'h2};
    $display("table test done");
    gap(0, g);
    check(g, 1023, "ref div max");
    gap(1, g);
    check(g, 31, "l2 div");
    {doubler_en, loop2_reference_divider} = {1'b1, 5'h04};
    gap(1, g);
    check(g, 2, "doubler");
    doubler_en = 1'b0;
    gap(2, g);
    check(g, 30, "fb div");
    {slow, primary_div_ratio} = {1'b1, 10'h003};
    gap(0, g);
    check(g, 6, "slow ref");
    slow = 1'b0;
    $display("divider test done");
    prim_on = 1'b0;
    cyc(1);
    check(active_is_secondary, 1, "auto");
    check(primary_present_stat, 0, "stat");
    gap(0, g);
    check(g, 7, "sec div");
    prim_on = 1'b1;
    cyc(2);
    check(active_is_secondary, 1, "nonrev");
    revertive = 1'b1;
    cyc(1);
    revertive = 1'b0;
    cyc(1);
    check(active_is_secondary, 1, "mode toggle");
    sec_on = 1'b0;
    cyc(1);
    check(active_is_secondary, 0, "sec lost");
    {sec_on, prim_on} = 2'h2;
    cyc(1);
    rst = 1'b1;
    cyc(1);
    {rst, revertive} = 2'h1;
    check(active_is_secondary, 0, "rst clears");
    cyc(1);
    check(active_is_secondary, 1, "rev out");
    prim_on = 1'b1;
    cyc(1);
    check(active_is_secondary, 0, "rev back");
    revertive = 1'b0;
    $display("switchover test done");
    {prim_on, sec_on} = 2'h0;
    cyc(1);
    check(holdover_active, 1, "hold in");
    check({cp_tristate, cp_force_mid}, 2'h2, "tri");
    gap(1, g);
    check(g, 4, "l2 in hold");
    holdover_mid_supply = 1'b1;
    cyc(1);
    check({cp_tristate, cp_force_mid}, 2'h1, "mid");
    check(secondary_present_stat, 0, "stat");
    prim_on = 1'b1;
    cyc(1);
    check({holdover_active, loop1_resync}, 2'h1, "exit");
    cyc(1);
    check(loop1_resync, 0, "resync");
    {holdover_mid_supply, holdover_disable, prim_on} = 3'h2;
    cyc(2);
    check(holdover_active, 0, "hold off");
    {holdover_disable, prim_on, sec_on} = 3'h3;
    $display("holdover test done");
    {auto_mode, manual_sel_secondary} = 2'h1;
    cyc(1);
    check(active_is_secondary, 1, "man cfg");
    use_select_pin = 1'b1;
    cyc(1);
    check(active_is_secondary, 0, "pin lo");
    ref_select_pin = 1'b1;
    cyc(1);
    check(active_is_secondary, 1, "pin hi");
    $display("manual test done");
    calibrate = 1'b1;
    cyc(1);
    check({cal_in_progress, cal_path_active}, 2'h3, "cal on");
    check(feedback_ratio, 30, "cal ratio");
    {cal_counter_b, cal_counter_a} = {6'h04, 2'h1};
    cyc(1);
    check(feedback_ratio, 17, "cal 4b+a");
    gap(2, g);
    check(g, 17, "cal fb div");
    cal_finished = 1'b1;
    cyc(1);
    cal_finished = 1'b0;
    check(cal_in_progress, 0, "cal end");
    check(feedback_ratio, 30, "normal path");
    cyc(3);
    check(cal_path_active, 0, "no restart");
    calibrate = 1'b0;
    $display("calibration test done");
    report_and_stop();
  end
endmodule
